// *** load_op_decoder.sv ***
// Purpose : Fetches, decodes and runs the 8-bit load group plus push/pop
// Assumes : Memory answers each request with a one-cycle mem_ack
// Notes   : Opcodes outside the group are consumed as one-byte no-ops
// Function
// - Opcode 48 copies register B into register C.
// - Opcode byte is fetched, decoded, then the transfer runs internally.
// - Opcode 72 writes register D to memory at pointer_pair.
// - Indexed loads are three bytes; third byte is signed displacement.
// - Accumulator load/store at direct address is opcode plus two bytes.
// - Direct address arrives low byte first, then high byte.
// - Immediate register load is two bytes; second byte is the value.
// - Indexed immediate store: prefix, opcode, displacement, value.
// - Displacement always comes right after the opcode, before immediate.
// - Push predecrements stack_pointer per byte; pop postincrements.
// - Opcode F5 pushes accumulator then flags.
// - Length of one to four bytes follows from opcode and prefix.
// - Indexed address is index plus signed displacement; index kept.
// - Push writes high byte first; pop reads high byte last.
`timescale 1ns/1ps

module load_op_decoder (
    input  wire logic                clock,
    input  wire logic                srst,
    input  wire logic [7:0]          mem_rdata,
    input  wire logic                mem_ack,
    output load_op_pkg::mem_req_t    mem_req,
    output load_op_pkg::arch_t       arch
);

    ////////////////////////////////////////////////////////////////////////
    // State
    // Only the register file and pointers are visible; the rest is the
    // sequencer's own bookkeeping for the instruction in flight

    load_op_pkg::state_t state;
    logic [7:0]          op;
    logic                use_ix;
    logic                use_iy;
    logic                phase;     // Second byte of a stack transfer
    logic [7:0]          imm;
    logic [15:0]         ea;
    logic [15:0]         pc;
    logic [15:0]         sp;
    logic [15:0]         ix;
    logic [15:0]         iy;
    logic [7:0]          rf [load_op_pkg::NUM_REG];

    ////////////////////////////////////////////////////////////////////////
    // Opcode field decode
    // Fields come from the latched opcode, never from the bus, so a
    // prefix fetch cannot disturb the instruction being decoded

    wire [1:0]  f_grp  = op[load_op_pkg::GRP_HI:load_op_pkg::GRP_LO];
    wire [2:0]  f_dst  = op[load_op_pkg::DST_HI:load_op_pkg::DST_LO];
    wire [2:0]  f_src  = op[load_op_pkg::SRC_HI:load_op_pkg::SRC_LO];
    wire [1:0]  f_pair = op[load_op_pkg::PAIR_HI:load_op_pkg::PAIR_LO];
    wire [3:0]  f_low  = op[load_op_pkg::LOW_HI:load_op_pkg::SRC_LO];
    wire        has_pfx = use_ix | use_iy;
    wire [15:0] idx     = use_iy ? iy : ix;

    // Instruction classes; the halt code is not a memory-to-memory copy
    wire is_rr   = (f_grp == load_op_pkg::GRP_RR)
                   && (op != load_op_pkg::OP_HALT);
    wire is_mn   = (op == load_op_pkg::OP_LD_MN);
    wire is_ldn  = (f_grp == load_op_pkg::GRP_LDN)
                   && (f_src == load_op_pkg::REG_MEM) && !is_mn;
    wire mem_src = is_rr && (f_src == load_op_pkg::REG_MEM);
    wire mem_dst = (is_rr && (f_dst == load_op_pkg::REG_MEM)) || is_mn;
    wire uses_hl = mem_src || mem_dst;
    wire is_ind  = (op == load_op_pkg::OP_LD_A_BC)
                   || (op == load_op_pkg::OP_LD_A_DE)
                   || (op == load_op_pkg::OP_ST_A_BC)
                   || (op == load_op_pkg::OP_ST_A_DE);
    wire is_nn   = (op == load_op_pkg::OP_LD_A_NN)
                   || (op == load_op_pkg::OP_ST_A_NN);
    wire a_store = (op == load_op_pkg::OP_ST_A_BC)
                   || (op == load_op_pkg::OP_ST_A_DE)
                   || (op == load_op_pkg::OP_ST_A_NN);
    wire is_push = (f_grp == load_op_pkg::GRP_STK)
                   && (f_low == load_op_pkg::LOW_PUSH);
    wire is_pop  = (f_grp == load_op_pkg::GRP_STK)
                   && (f_low == load_op_pkg::LOW_POP);

    // Memory phase direction, data and load target
    wire       mem_wr  = mem_dst || a_store;
    wire [7:0] mem_wd  = is_mn ? imm
                         : (a_store ? rf[load_op_pkg::REG_A] : rf[f_src]);
    wire [2:0] ld_dst  = is_rr ? f_dst : load_op_pkg::REG_A;

    // Pointers for register indirect forms; 0a/02 use BC, 1a/12 use DE
    wire [15:0] hl      = {rf[load_op_pkg::REG_H], rf[load_op_pkg::REG_L]};
    wire [15:0] ind_ptr = {rf[{f_pair, 1'b0}], rf[{f_pair, 1'b1}]};
    wire [15:0] disp    = {{8{mem_rdata[7]}}, mem_rdata};

    // Stack pair halves; prefix swaps pointer_pair for an index register
    wire       pair_idx = has_pfx && (f_pair == load_op_pkg::PAIR_PP);
    wire       pair_af  = (f_pair == load_op_pkg::PAIR_AF);
    wire [2:0] hi_code  = pair_af ? load_op_pkg::REG_A : {f_pair, 1'b0};
    wire [2:0] lo_code  = pair_af ? load_op_pkg::REG_F : {f_pair, 1'b1};
    wire [7:0] hi_val   = pair_idx ? idx[15:8] : rf[hi_code];
    wire [7:0] lo_val   = pair_idx ? idx[7:0] : rf[lo_code];
    // Both neighbours of the stack pointer are formed up front; the stack
    // state picks one, which keeps stack pointer arithmetic out of the sequencer
    wire [15:0] sp_dec  = sp - load_op_pkg::ONE16;
    wire [15:0] sp_inc  = sp + load_op_pkg::ONE16;

    ////////////////////////////////////////////////////////////////////////
    // Bus request selection per state
    // Every byte taken from the instruction stream is read at pc

    wire pc_state  = (state == load_op_pkg::S_FETCH)
                     || (state == load_op_pkg::S_DISP)
                     || (state == load_op_pkg::S_IMM)
                     || (state == load_op_pkg::S_ALO)
                     || (state == load_op_pkg::S_AHI);
    wire mem_state = (state == load_op_pkg::S_MEM);
    wire stk_state = (state == load_op_pkg::S_STK);
    wire need_bus  = pc_state || mem_state || stk_state;
    wire busy      = mem_req.rd || mem_req.wr;
    wire got       = busy && mem_ack;   // Transfer finished this edge

    // Push writes at the predecremented pointer, pop reads at the pointer
    wire [15:0] stk_addr = is_push ? sp_dec : sp;
    wire [7:0]  stk_wd   = phase ? lo_val : hi_val;
    wire [15:0] bus_addr = pc_state ? pc : (mem_state ? ea : stk_addr);
    wire        bus_wr   = (mem_state && mem_wr) || (stk_state && is_push);
    wire [7:0]  bus_wd   = mem_state ? mem_wd : stk_wd;

    ////////////////////////////////////////////////////////////////////////
    // Request register; held until memory acknowledges
    // Dropping the request for a cycle after each ack costs one clock per
    // byte but lets memory treat every rising rd or wr as a fresh cycle

    always_ff @(posedge clock) begin
        if (srst) begin
            mem_req <= '0;
        end else if (busy) begin
            if (mem_ack) begin
                mem_req <= '0;
            end
        end else if (need_bus) begin
            mem_req.fetch <= (state == load_op_pkg::S_FETCH);
            mem_req.rd    <= !bus_wr;
            mem_req.wr    <= bus_wr;
            mem_req.addr  <= bus_addr;
            mem_req.wdata <= bus_wr ? bus_wd : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and datapath; length grows only by the bytes a form needs

    always_ff @(posedge clock) begin
        if (srst) begin
            state  <= load_op_pkg::S_FETCH;
            op     <= '0;
            use_ix <= 1'b0;
            use_iy <= 1'b0;
            phase  <= 1'b0;
            imm    <= '0;
            ea     <= '0;
            pc     <= load_op_pkg::PC_RESET;
            sp     <= load_op_pkg::SP_RESET;
            ix     <= '0;
            iy     <= '0;
            for (int i = 0; i < load_op_pkg::NUM_REG; i++) begin
                rf[i] <= '0;
            end
        end else begin
            if (got && pc_state) begin
                pc <= pc + load_op_pkg::ONE16;
            end
            case (state)
                load_op_pkg::S_FETCH: if (got) begin
                    // A prefix adds a byte and keeps fetching
                    if (mem_rdata == load_op_pkg::OP_PFX_X) begin
                        use_ix <= 1'b1;
                        use_iy <= 1'b0;
                    end else if (mem_rdata == load_op_pkg::OP_PFX_Y) begin
                        use_ix <= 1'b0;
                        use_iy <= 1'b1;
                    end else begin
                        op    <= mem_rdata;
                        state <= load_op_pkg::S_DECODE;
                    end
                end
                load_op_pkg::S_DECODE: begin
                    phase <= 1'b0;
                    // Stack forms go first: a prefixed push has no d byte
                    if (is_push || is_pop) begin
                        state <= load_op_pkg::S_STK;
                    end else if (uses_hl && has_pfx) begin
                        state <= load_op_pkg::S_DISP;
                    end else if (is_ldn || is_mn) begin
                        ea    <= hl;
                        state <= load_op_pkg::S_IMM;
                    end else if (is_nn) begin
                        state <= load_op_pkg::S_ALO;
                    end else if (uses_hl) begin
                        ea    <= hl;
                        state <= load_op_pkg::S_MEM;
                    end else if (is_ind) begin
                        ea    <= ind_ptr;
                        state <= load_op_pkg::S_MEM;
                    end else begin
                        // Register copy done inside, e.g. 48 is B to C
                        if (is_rr) begin
                            rf[f_dst] <= rf[f_src];
                        end
                        use_ix <= 1'b0;
                        use_iy <= 1'b0;
                        state  <= load_op_pkg::S_FETCH;
                    end
                end
                load_op_pkg::S_DISP: if (got) begin
                    // Index register itself is never written here
                    ea    <= idx + disp;
                    state <= is_mn ? load_op_pkg::S_IMM
                                   : load_op_pkg::S_MEM;
                end
                load_op_pkg::S_IMM: if (got) begin
                    // Memory-bound immediate waits in imm for its write
                    if (is_mn) begin
                        imm   <= mem_rdata;
                        state <= load_op_pkg::S_MEM;
                    end else begin
                        rf[f_dst] <= mem_rdata;
                        use_ix    <= 1'b0;
                        use_iy    <= 1'b0;
                        state     <= load_op_pkg::S_FETCH;
                    end
                end
                load_op_pkg::S_ALO: if (got) begin
                    ea[7:0] <= mem_rdata;
                    state   <= load_op_pkg::S_AHI;
                end
                load_op_pkg::S_AHI: if (got) begin
                    ea[15:8] <= mem_rdata;
                    state    <= load_op_pkg::S_MEM;
                end
                load_op_pkg::S_MEM: if (got) begin
                    // Single access at the effective address
                    if (!mem_wr) begin
                        rf[ld_dst] <= mem_rdata;
                    end
                    use_ix <= 1'b0;
                    use_iy <= 1'b0;
                    state  <= load_op_pkg::S_FETCH;
                end
                load_op_pkg::S_STK: if (got) begin
                    // Pointer moves once per byte
                    sp    <= is_push ? sp_dec : sp_inc;
                    phase <= 1'b1;
                    if (is_pop && !phase) begin
                        // Low half comes off first
                        if (pair_idx && use_iy) begin
                            iy[7:0] <= mem_rdata;
                        end else if (pair_idx) begin
                            ix[7:0] <= mem_rdata;
                        end else begin
                            rf[lo_code] <= mem_rdata;
                        end
                    end else if (is_pop) begin
                        // High half last, undoing push order
                        if (pair_idx && use_iy) begin
                            iy[15:8] <= mem_rdata;
                        end else if (pair_idx) begin
                            ix[15:8] <= mem_rdata;
                        end else begin
                            rf[hi_code] <= mem_rdata;
                        end
                    end
                    if (phase) begin
                        use_ix <= 1'b0;
                        use_iy <= 1'b0;
                        state  <= load_op_pkg::S_FETCH;
                    end
                end
                // Unused encodings fall back to fetching; no state sticks
                default: state <= load_op_pkg::S_FETCH;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Visible state, wired straight from the flip-flops
    // Continuous wiring only: every field below is a register above

    assign arch.a                = rf[load_op_pkg::REG_A];
    assign arch.f                = rf[load_op_pkg::REG_F];
    assign arch.b                = rf[load_op_pkg::REG_B];
    assign arch.c                = rf[load_op_pkg::REG_C];
    assign arch.d                = rf[load_op_pkg::REG_D];
    assign arch.e                = rf[load_op_pkg::REG_E];
    assign arch.h                = rf[load_op_pkg::REG_H];
    assign arch.l                = rf[load_op_pkg::REG_L];
    assign arch.first_index_reg  = ix;
    assign arch.second_index_reg = iy;
    assign arch.stack_pointer    = sp;
    assign arch.pc               = pc;

endmodule

// *** load_op_decoder_properties.sv ***
// Purpose : Port-level properties of the load group decoder
// Assumes : Single clock domain, synchronous active-high reset
// Notes   : Bound to every instance of the decoder
`timescale 1ns/1ps
module load_op_decoder_properties (
    input wire logic                  clock,
    input wire logic                  srst,
    input wire logic                  mem_ack,
    input wire load_op_pkg::mem_req_t mem_req,
    input wire load_op_pkg::arch_t    arch
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    wire req = mem_req.rd | mem_req.wr;

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: a request stands until acked, then idles a cycle
    property p_first_fetch;
        $fell(srst) |-> mem_req == '0
            && arch.stack_pointer == load_op_pkg::SP_RESET
            ##1 mem_req.fetch && mem_req.rd
            && mem_req.addr == load_op_pkg::PC_RESET;
    endproperty
    a_first_fetch: assert property (p_first_fetch)
        else $error("no opcode fetch at zero after reset");
    property p_hold;
        req && !mem_ack |=> $stable(mem_req);
    endproperty
    a_hold: assert property (p_hold)
        else $error("request changed before ack");
    property p_gap;
        req && mem_ack |=> !req;
    endproperty
    a_gap: assert property (p_gap)
        else $error("request repeated right after ack");
    property p_read_only;
        mem_req.rd |-> !mem_req.wr && mem_req.wdata == 8'h00;
    endproperty
    a_read_only: assert property (p_read_only)
        else $error("read and write mixed");
    property p_fetch_pc;
        mem_req.fetch |-> mem_req.rd && mem_req.addr == arch.pc;
    endproperty
    a_fetch_pc: assert property (p_fetch_pc)
        else $error("fetch not at program counter");

    // Program counter and stack pointer move one step per acked byte
    property p_pc_step;
        $changed(arch.pc) |-> $past(mem_ack)
            && arch.pc == $past(arch.pc) + 16'h0001;
    endproperty
    a_pc_step: assert property (p_pc_step)
        else $error("program counter jumped");
    property p_sp_step;
        $changed(arch.stack_pointer) |-> $past(mem_ack)
            && (arch.stack_pointer == $past(arch.stack_pointer) - 16'h0001
            || arch.stack_pointer == $past(arch.stack_pointer) + 16'h0001);
    endproperty
    a_sp_step: assert property (p_sp_step)
        else $error("stack pointer moved wrongly");
    // Index registers may only move on the ack of a memory read
    property p_index_kept;
        !(mem_req.rd && mem_ack) |=> $stable(arch.first_index_reg)
            && $stable(arch.second_index_reg);
    endproperty
    a_index_kept: assert property (p_index_kept)
        else $error("index register altered");
endmodule

bind load_op_decoder load_op_decoder_properties u_props (
    .clock(clock), .srst(srst), .mem_ack(mem_ack),
    .mem_req(mem_req), .arch(arch));

// *** load_op_pkg.sv ***
// Purpose : Shared constants and types for the load group decoder
// Assumes : Opcode fields follow the 2-3-3 bit layout of the opcode byte
// Notes   : Register codes double as array indexes into the register file
package load_op_pkg;

    localparam logic [7:0]  OP_PFX_X   = 8'hdd; // Selects first_index_reg
    localparam logic [7:0]  OP_PFX_Y   = 8'hfd; // Selects second_index_reg
    localparam logic [7:0]  OP_LD_MN   = 8'h36; // Immediate byte to memory
    localparam logic [7:0]  OP_HALT    = 8'h76; // Hole in the copy block
    localparam logic [7:0]  OP_LD_A_BC = 8'h0a;
    localparam logic [7:0]  OP_LD_A_DE = 8'h1a;
    localparam logic [7:0]  OP_ST_A_BC = 8'h02;
    localparam logic [7:0]  OP_ST_A_DE = 8'h12;
    localparam logic [7:0]  OP_LD_A_NN = 8'h3a;
    localparam logic [7:0]  OP_ST_A_NN = 8'h32;

    // Opcode field positions
    localparam int GRP_HI  = 7;
    localparam int GRP_LO  = 6;
    localparam int DST_HI  = 5;
    localparam int DST_LO  = 3;
    localparam int SRC_HI  = 2;
    localparam int SRC_LO  = 0;
    localparam int PAIR_HI = 5;
    localparam int PAIR_LO = 4;
    localparam int LOW_HI  = 3;

    localparam logic [1:0] GRP_LDN  = 2'h0; // Immediate loads live here
    localparam logic [1:0] GRP_RR   = 2'h1; // Register to register copies
    localparam logic [1:0] GRP_STK  = 2'h3; // Push and pop live here
    localparam logic [3:0] LOW_PUSH = 4'h5;
    localparam logic [3:0] LOW_POP  = 4'h1;
    localparam logic [1:0] PAIR_PP  = 2'h2; // pointer_pair slot
    localparam logic [1:0] PAIR_AF  = 2'h3;

    // Register codes; code 6 means memory in opcodes, so flags sit there
    localparam logic [2:0] REG_B   = 3'h0;
    localparam logic [2:0] REG_C   = 3'h1;
    localparam logic [2:0] REG_D   = 3'h2;
    localparam logic [2:0] REG_E   = 3'h3;
    localparam logic [2:0] REG_H   = 3'h4;
    localparam logic [2:0] REG_L   = 3'h5;
    localparam logic [2:0] REG_MEM = 3'h6;
    localparam logic [2:0] REG_F   = 3'h6;
    localparam logic [2:0] REG_A   = 3'h7;
    localparam int         NUM_REG = 8;

    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'hffff;
    localparam logic [15:0] ONE16    = 16'h0001;

    typedef enum logic [3:0] {
        S_FETCH, S_DECODE, S_DISP, S_IMM, S_ALO, S_AHI, S_MEM, S_STK
    } state_t;

    // One memory cycle request toward external memory
    typedef struct packed {
        logic        fetch;   // opcode_fetch_cycle marker
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mem_req_t;

    // Programmer visible state
    typedef struct packed {
        logic [7:0]  a;
        logic [7:0]  f;
        logic [7:0]  b;
        logic [7:0]  c;
        logic [7:0]  d;
        logic [7:0]  e;
        logic [7:0]  h;
        logic [7:0]  l;
        logic [15:0] first_index_reg;
        logic [15:0] second_index_reg;
        logic [15:0] stack_pointer;
        logic [15:0] pc;
    } arch_t;

endpackage

// *** mem_model.sv ***
// Purpose : Behavioural program and data memory facing the decoder
// Assumes : One request at a time, held until it is acknowledged
// Notes   : Read data toggles when not driven, so stale bytes never pass
`timescale 1ns/1ps
module mem_model (
    input  wire logic                  clock,
    input  wire logic                  srst,
    input  wire logic                  slow,
    input  wire load_op_pkg::mem_req_t mem_req,
    output logic [7:0]                 mem_rdata,
    output logic                       mem_ack
);
    logic [7:0] mem [0:65535];
    logic [1:0] wait_cnt;
    wire        busy = (mem_req.rd | mem_req.wr) & ~mem_ack;
    wire        due  = wait_cnt == (slow ? 2'h3 : 2'h0);

    ////////////////////////////////////////////////////////////////////////
    // Clear contents so fetches past the program decode as plain bytes
    initial begin
        mem_rdata = 8'h00;
        mem_ack   = 1'b0;
        wait_cnt  = 2'h0;
        foreach (mem[i]) begin
            mem[i] = 8'h00;
        end
    end

    // Ack one cycle after the request, or four cycles after it when slow
    always @(posedge clock) begin
        mem_ack   <= 1'b0;
        mem_rdata <= ~mem_rdata;
        wait_cnt  <= 2'h0;
        if (!srst && busy && due) begin
            mem_ack <= 1'b1;
            if (mem_req.wr) begin
                mem[mem_req.addr] <= mem_req.wdata;
            end else begin
                mem_rdata <= mem[mem_req.addr];
            end
        end else if (!srst && busy) begin
            wait_cnt <= wait_cnt + 2'h1;
        end
    end
endmodule

// *** tb_top.sv ***
// Purpose : Self-checking bench for the load group decoder
// Assumes : Memory model answers the bus; bench drives on falling edges
// Notes   : Program runs twice, prompt then slow memory, reset mid-run
`timescale 1ns/1ps
module tb_top;
    typedef struct {
        logic [31:0] code; // Instruction bytes, first byte on top
        int          len;  // Zero adds a check to the row above
        int          sel;  // Register code, 8 selects a memory byte
        logic [15:0] addr;
        logic [7:0]  exp;
    } row_t;
    logic                  clock = 1'b0;
    logic                  srst  = 1'b1;
    logic                  slow  = 1'b0;
    logic [7:0]            mem_rdata;
    logic                  mem_ack;
    load_op_pkg::mem_req_t mem_req;
    load_op_pkg::arch_t    arch;
    int                    n_mismatch = 0;
    int                    n_tests    = 0;
    int                    cycles     = 0;
    logic [15:0]           at;
    row_t                  rows [26];

    load_op_decoder dut (.clock(clock), .srst(srst), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .mem_req(mem_req), .arch(arch));
    mem_model u_mem (.clock(clock), .srst(srst), .slow(slow),
        .mem_req(mem_req), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

    ////////////////////////////////////////////////////////////////////////
    // Clock and a cycle ceiling well above two program passes
    always #4 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_mismatch = n_mismatch + 1;
            summarize();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("Counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    function automatic logic [7:0] seen(input row_t r);
        case (r.sel)
            0: return arch.b;
            1: return arch.c;
            2: return arch.d;
            3: return arch.e;
            4: return arch.h;
            5: return arch.l;
            7: return arch.a;
            default: return u_mem.mem[r.addr];
        endcase
    endfunction

    // Lay the program from zero; clear checked bytes so old results fail
    task automatic preload;
        at = 16'h0000;
        foreach (rows[i]) begin
            if (rows[i].sel == 8) begin
                u_mem.mem[rows[i].addr] = 8'h00;
            end
            for (int j = 0; j < rows[i].len; j++) begin
                u_mem.mem[at + 16'(j)] = rows[i].code[31 - 8 * j -: 8];
            end
            at = at + 16'(rows[i].len);
        end
        u_mem.mem[16'h9100] = 8'h77;
        u_mem.mem[16'h7700] = 8'h96;
        u_mem.mem[16'hfffd] = 8'hff;
    endtask

    // Bounded wait for the opcode fetch that starts the next instruction
    task automatic wait_fetch(input logic [15:0] a);
        int n;
        n = 0;
        while (!(mem_req.fetch === 1'b1 && mem_req.addr === a) && n < 400) begin
            @(negedge clock);
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reset checks, then program rows, then index and stack checks per pass
    initial begin
        rows = '{
            '{32'h06110000, 2, 0, 16'h0000, 8'h11},
            '{32'h48000000, 1, 1, 16'h0000, 8'h11},
            '{32'h165a0000, 2, 2, 16'h0000, 8'h5a},
            '{32'h26800000, 2, 4, 16'h0000, 8'h80},
            '{32'h2e100000, 2, 5, 16'h0000, 8'h10},
            '{32'h72000000, 1, 8, 16'h8010, 8'h5a},
            '{32'h3ec30000, 2, 7, 16'h0000, 8'hc3},
            '{32'h32349000, 3, 8, 16'h9034, 8'hc3},
            '{32'h3a009100, 3, 7, 16'h0000, 8'h77},
            '{32'hdd3680a5, 4, 8, 16'hff80, 8'ha5},
            '{32'hfd367f3c, 4, 8, 16'h007f, 8'h3c},
            '{32'hdd5e8000, 3, 3, 16'h0000, 8'ha5},
            '{32'hf5000000, 1, 8, 16'hfffe, 8'h77},
            '{32'h00000000, 0, 8, 16'hfffd, 8'h00},
            '{32'hc1000000, 1, 0, 16'h0000, 8'h77},
            '{32'h00000000, 0, 1, 16'h0000, 8'h00},
            '{32'hd5000000, 1, 8, 16'hfffe, 8'h5a},
            '{32'he1000000, 1, 5, 16'h0000, 8'ha5},
            '{32'h00000000, 0, 4, 16'h0000, 8'h5a},
            '{32'h12000000, 1, 8, 16'h5aa5, 8'h77},
            '{32'h0a000000, 1, 7, 16'h0000, 8'h96},
            '{32'h1a000000, 1, 7, 16'h0000, 8'h77},
            '{32'h02000000, 1, 8, 16'h7700, 8'h77},
            '{32'he5000000, 1, 8, 16'hfffe, 8'h5a},
            '{32'hdde10000, 2, 8, 16'hfffd, 8'ha5},
            '{32'hdd6e0000, 3, 5, 16'h0000, 8'h77}
        };
        @(negedge clock);
        for (int pass = 0; pass < 2; pass++) begin
            // Second pass resets with a fetch still outstanding
            srst = 1'b1;
            slow = (pass == 1);
            @(negedge clock);
            check(32'(mem_req), 32'h0);
            check(32'(arch.stack_pointer), 32'hffff);
            preload();
            repeat (7) @(negedge clock);
            srst = 1'b0;
            at = 16'h0000;
            foreach (rows[i]) begin
                if (rows[i].len > 0) begin
                    at = at + 16'(rows[i].len);
                    wait_fetch(at);
                    check(32'(mem_req.addr), 32'(at));
                end
                check(32'(seen(rows[i])), 32'(rows[i].exp));
            end
            check(32'(arch.first_index_reg), 32'h5aa5);
            check(32'(arch.second_index_reg), 32'h0);
            check(32'(arch.stack_pointer), 32'hffff);
            $display("Program pass %0d done, slow memory %0d", pass, slow);
        end
        summarize();
    end
endmodule
